// File: adpo_capture.sv
`timescale 1ns/1ps
`default_nettype none
module adpo_capture #(
  parameter int HALF_PERIOD = 1,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  adpo_link_if.capture link,
  input wire logic run,
  output logic wordValid,
  input wire logic wordReady,
  output logic [adpo_pkg::DATA_W-1:0] wordCode,
  output logic wordOutOfRange,
  output logic flushing
);
  import adpo_pkg::*;

  // R8: period bound
  if (HALF_PERIOD < 1 || 2 * HALF_PERIOD > MAX_PERIOD_CYC) begin : g_periodChk
    $error("adpo_capture: encode period too long for minimum rate");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b100
  } adpo_state_t;

  ////////////////////////////////////////////////////////////////////////////
  adpo_state_t state_q, state_d;
  logic [7:0] phase_q, phase_d;
  logic [3:0] edges_q, edges_d;
  logic enc_q, enc_d;
  logic bufReady;
  logic push;
  logic canRise;
  adpo_word_t captured, popped;

  assign canRise = run && bufReady;
  assign captured = '{outOfRange: link.outOfRange, code: link.dataWord};

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    edges_d = edges_q;
    enc_d = enc_q;
    push = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (canRise) begin
          state_d = ST_HIGH;
          enc_d = 1'b1;
          phase_d = 8'(HALF_PERIOD - 1);
          // R10: flush restarts
          edges_d = 4'h1;
        end
      end
      ST_HIGH: begin
        if (phase_q == 8'h00) begin
          state_d = ST_LOW;
          enc_d = 1'b0;
          phase_d = 8'(HALF_PERIOD - 1);
        end else begin
          phase_d = phase_q - 8'h01;
        end
      end
      ST_LOW: begin
        if (phase_q != 8'h00) begin
          phase_d = phase_q - 8'h01;
        end else if (canRise) begin
          // R11: equal halves
          state_d = ST_HIGH;
          enc_d = 1'b1;
          phase_d = 8'(HALF_PERIOD - 1);
          // R12: count edges
          if (edges_q != 4'(FLUSH_EDGES + 1)) begin
            edges_d = edges_q + 4'h1;
          end
          // R4: word of previous edge
          push = (edges_q > 4'(FLUSH_EDGES));
        end else begin
          // stalling stops the clock, so the next start flushes again
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        enc_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      phase_q <= 8'h00;
      edges_q <= 4'h0;
      enc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      edges_q <= edges_d;
      enc_q <= enc_d;
    end
  end

  assign link.encode = enc_q;
  // R10: invalid until flushed
  assign flushing = (state_q != ST_IDLE) && (edges_q <= 4'(FLUSH_EDGES));

  adpo_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(push),
    .inReady(bufReady),
    .inData(captured),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(popped)
  );

  assign wordCode = popped.code;
  assign wordOutOfRange = popped.outOfRange;
endmodule : adpo_capture
`default_nettype wire

// File: adpo_pkg.sv
// Functional notes
// R1: sample input on every encode rising edge
// R2: one corrected 10-bit word per conversion
// R3: output word updates on rising edge, latched
// R4: output belongs to sample five edges earlier
// R5: above span all ones, below all zeros
// R6: range flag high only when outside span; code also sets it in the RECOVER_CYC window after re-entry
// R7: valid codes resume shortly after re-entry
// R8: encode rate kept at least 3 MSPS
// R9: below 1.5 MSPS hold stops, track only
// R10: five flush pulses after every clock restart
// R11: encode pulse width within ten percent
// R12: receiver counts edges to mark valid words
package adpo_pkg;
  localparam int DATA_W = 10;
  localparam int COARSE_W = 5;
  localparam int FINE_W = 6;
  // fine stage overlaps the coarse step by half a step each way
  localparam int FINE_OFFSET = 16;
  localparam int LATENCY = 5;
  localparam int FLUSH_EDGES = 5;
  localparam int CLK_NS = 100;
  localparam int MIN_RATE_KSPS = 3000;
  localparam int TRACK_RATE_KSPS = 1500;
  localparam int RECOVER_NS = 10;
  localparam int PW_TOL_PCT = 10;
  // longest encode period that still meets the minimum rate, rounded down
  localparam int MAX_PERIOD_CYC = 1000000 / (MIN_RATE_KSPS * CLK_NS);
  // gap after which the hold is dropped, rounded up
  localparam int SLOW_CYC = (1000000 + TRACK_RATE_KSPS * CLK_NS - 1) / (TRACK_RATE_KSPS * CLK_NS);
  localparam int RECOVER_CYC = (RECOVER_NS / CLK_NS) < 1 ? 1 : (RECOVER_NS / CLK_NS);
  localparam logic [DATA_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic [DATA_W-1:0] CODE_MIN = 10'h000;
  localparam logic [DATA_W-1:0] CODE_RESET = 10'h000;

  typedef struct packed {
    logic outOfRange;
    logic [DATA_W-1:0] code;
  } adpo_word_t;

  // merge coarse and fine results, removing the overlap and clamping
  function automatic logic [DATA_W-1:0] adpoCorrect(input logic [COARSE_W-1:0] coarse,
                                                   input logic [FINE_W-1:0] fine);
    logic [DATA_W+1:0] sum;
    sum = {2'b00, coarse, 5'h00} + {6'h00, fine};
    if (sum < (DATA_W+2)'(FINE_OFFSET)) begin
      return CODE_MIN;
    end
    sum = sum - (DATA_W+2)'(FINE_OFFSET);
    if (sum > {2'b00, CODE_MAX}) begin
      return CODE_MAX;
    end
    return sum[DATA_W-1:0];
  endfunction : adpoCorrect
endpackage : adpo_pkg

// File: adpo_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adpo_link_if;
  import adpo_pkg::*;
  logic encode;
  logic [DATA_W-1:0] dataWord;
  logic outOfRange;
  modport converter (input encode, output dataWord, output outOfRange);
  modport capture (output encode, input dataWord, input outOfRange);
endinterface : adpo_link_if
`default_nettype wire

// File: adpo_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module adpo_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_depthChk
    $error("adpo_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PTR_W:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (PTR_W+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage carries no reset; only the occupancy count gates its use
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule : adpo_fifo
`default_nettype wire

// File: adpo_converter.sv
`timescale 1ns/1ps
`default_nettype none
module adpo_converter #(
  parameter int LAT = adpo_pkg::LATENCY
) (
  input wire logic clk_sys,
  input wire logic rst,
  adpo_link_if.converter link,
  input wire logic [adpo_pkg::COARSE_W-1:0] coarseCode,
  input wire logic [adpo_pkg::FINE_W-1:0] fineCode,
  input wire logic aboveSpan,
  input wire logic belowSpan,
  output logic trackOnly
);
  import adpo_pkg::*;

  if (LAT < 1 || LAT > 16) begin : g_latChk
    $error("adpo_converter: LAT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic encPrev_q, encPrev_d;
  logic rise;
  logic [7:0] gapCnt_q, gapCnt_d;
  logic trackOnly_q, trackOnly_d;
  logic [3:0] recCnt_q, recCnt_d;
  logic clampHi_q, clampHi_d;
  adpo_word_t pipe_q [LAT];
  adpo_word_t pipe_d [LAT];
  adpo_word_t out_q, out_d;
  adpo_word_t fresh;
  logic outside;

  // R1: start on rising edge
  assign rise = link.encode && !encPrev_q;
  assign outside = aboveSpan || belowSpan;

  always_comb begin
    encPrev_d = link.encode;
    gapCnt_d = rise ? 8'h00 : (gapCnt_q == 8'hFF ? gapCnt_q : gapCnt_q + 8'h01);
    // R9: slow clock drops hold
    trackOnly_d = (gapCnt_q >= 8'(SLOW_CYC - 1)) && !rise;
    // R7: short recovery after re-entry
    if (outside) begin
      recCnt_d = 4'(RECOVER_CYC);
      clampHi_d = aboveSpan;
    end else begin
      recCnt_d = (recCnt_q != 4'h0) ? recCnt_q - 4'h1 : 4'h0;
      clampHi_d = clampHi_q;
    end
    // R2: corrected 10-bit word
    fresh.code = adpoCorrect(coarseCode, fineCode);
    fresh.outOfRange = 1'b0;
    // R5: clamp at full scale
    if (outside) begin
      fresh.code = aboveSpan ? CODE_MAX : CODE_MIN;
      // R6: range flag high
      fresh.outOfRange = 1'b1;
    end else if (recCnt_q != 4'h0) begin
      fresh.code = clampHi_q ? CODE_MAX : CODE_MIN;
      fresh.outOfRange = 1'b1;
    end
    for (int i = 0; i < LAT; i++) begin
      pipe_d[i] = pipe_q[i];
    end
    out_d = out_q;
    // R4: five edge latency
    if (rise) begin
      out_d = pipe_q[LAT-1];
      for (int i = LAT - 1; i > 0; i--) begin
        pipe_d[i] = pipe_q[i-1];
      end
      pipe_d[0] = fresh;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      encPrev_q <= 1'b0;
      gapCnt_q <= 8'h00;
      trackOnly_q <= 1'b0;
      recCnt_q <= 4'h0;
      clampHi_q <= 1'b0;
      out_q <= '{outOfRange: 1'b0, code: CODE_RESET};
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= '{outOfRange: 1'b0, code: CODE_RESET};
      end
    end else begin
      encPrev_q <= encPrev_d;
      gapCnt_q <= gapCnt_d;
      trackOnly_q <= trackOnly_d;
      recCnt_q <= recCnt_d;
      clampHi_q <= clampHi_d;
      out_q <= out_d;
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  // R3: latched between edges
  assign link.dataWord = out_q.code;
  assign link.outOfRange = out_q.outOfRange;
  assign trackOnly = trackOnly_q;
endmodule : adpo_converter
`default_nettype wire

// File: adpo_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adpo_link_sva
  import adpo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic encode,
  input wire logic [DATA_W-1:0] dataWord,
  input wire logic outOfRange
);
  logic encPrev_q;
  logic [2:0] rises_q;
  ////////////////////////////////////////
  // rises since reset, saturating; below six the pipe still shows reset zeros
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      encPrev_q <= 1'b0;
      rises_q <= 3'h0;
    end else begin
      encPrev_q <= encode;
      if (encode && !encPrev_q && rises_q != 3'h7) begin
        rises_q <= rises_q + 3'h1;
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_hold; !$rose(encode) |=> $stable(dataWord); endproperty
  a_hold: assert property (p_hold) else $error("word moved without rise");
  property p_wchg; $changed(dataWord) |-> $past(encode) && !$past(encode, 2); endproperty
  a_wchg: assert property (p_wchg) else $error("word update off rise");
  property p_fchg; $changed(outOfRange) |-> $past(encode) && !$past(encode, 2); endproperty
  a_fchg: assert property (p_fchg) else $error("flag update off rise");
  property p_clamp; outOfRange |-> dataWord == CODE_MAX || dataWord == CODE_MIN; endproperty
  a_clamp: assert property (p_clamp) else $error("flag set on unclamped word");
  property p_pulse; $rose(encode) |=> $fell(encode); endproperty
  a_pulse: assert property (p_pulse) else $error("encode high too long");
  property p_pipe0; rises_q < 3'h6 |-> dataWord == CODE_RESET && !outOfRange; endproperty
  a_pipe0: assert property (p_pipe0) else $error("word ahead of pipe depth");
  property p_rdat; $fell(rst) |-> dataWord == CODE_RESET && !outOfRange; endproperty
  a_rdat: assert property (p_rdat) else $error("word not cleared");
  property p_renc; $fell(rst) |-> !encode; endproperty
  a_renc: assert property (p_renc) else $error("encode high after reset");
endmodule : adpo_link_sva
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adpo_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [COARSE_W-1:0] coarseCode = 5'h00;
  logic [FINE_W-1:0] fineCode = 6'h00;
  logic aboveSpan = 1'b0;
  logic belowSpan = 1'b0;
  logic run = 1'b0;
  logic wordReady = 1'b0;
  logic trackOnly, wordValid, wordOutOfRange, flushing;
  logic [DATA_W-1:0] wordCode;
  int bad_count = 0;
  int checks_done = 0;
  logic [DATA_W:0] burst[$];
  logic [DATA_W:0] expq[$];
  logic [3:0] recLeft = 4'h0;
  logic recHi = 1'b0;
  logic [1:0] lowCnt = 2'h0;
  logic encPrev = 1'b0;
  adpo_link_if link ();
  adpo_converter i_adpo_converter (.clk_sys, .rst, .link, .coarseCode, .fineCode,
    .aboveSpan, .belowSpan, .trackOnly);
  adpo_capture i_adpo_capture (.clk_sys, .rst, .link, .run, .wordValid, .wordReady,
    .wordCode, .wordOutOfRange, .flushing);
  adpo_link_sva i_adpo_link_sva (.clk_sys, .rst, .encode(link.encode),
    .dataWord(link.dataWord), .outOfRange(link.outOfRange));
  ////////////////////////////////////////
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    coarseCode <= coarseCode + 5'h07;
    fineCode <= fineCode + 6'h0D;
  end
  task automatic chk(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // samples of the running burst; sample k comes out at rise k+6
  always @(posedge clk_sys) begin : mon
    logic [1:0] cl;
    logic [11:0] s;
    if (rst) begin
      burst.delete();
      expq.delete();
      recLeft = 4'h0;
      recHi = 1'b0;
      encPrev = 1'b0;
    end else begin
      if (link.encode && !encPrev) begin
        if (lowCnt > 2'h1) burst.delete();
        // clamp lingers for the recovery time in clocks, not in samples
        cl = aboveSpan ? 2'h2 : belowSpan ? 2'h1 : recLeft != 4'h0 ? (recHi ? 2'h2 : 2'h1) : 2'h0;
        s = {2'b00, coarseCode, 5'h00} + {6'h00, fineCode};
        burst.push_back(cl == 2'h2 ? 11'h7FF : cl == 2'h1 ? 11'h400 : s < 12'h010 ? 11'h000 :
          s > 12'h40F ? 11'h3FF : {1'b0, s[9:0] - 10'h010});
        if (burst.size() > 6) expq.push_back(burst.pop_front());
      end
      lowCnt = link.encode ? 2'h0 : (lowCnt == 2'h2 ? lowCnt : lowCnt + 2'h1);
      if (aboveSpan || belowSpan) begin
        recLeft = 4'(RECOVER_CYC);
        recHi = aboveSpan;
      end else if (recLeft != 4'h0) begin
        recLeft = recLeft - 4'h1;
      end
      encPrev = link.encode;
      if (wordValid === 1'b1 && wordReady) begin
        chk({wordOutOfRange, wordCode}, expq.size() != 0 ? expq.pop_front() : 11'h555);
      end
    end
  end
  task automatic t_stream;
    run = 1'b1;
    wordReady = 1'b1;
    cyc(60);
  endtask : t_stream
  task automatic t_range;
    aboveSpan = 1'b1;
    cyc(8);
    aboveSpan = 1'b0;
    belowSpan = 1'b1;
    // odd length puts the first rise after re-entry inside the recovery window
    cyc(9);
    belowSpan = 1'b0;
    cyc(30);
  endtask : t_range
  task automatic t_stall;
    wordReady = 1'b0;
    cyc(40);
    chk({10'h000, wordValid}, 11'h001);
    chk({10'h000, trackOnly}, 11'h001);
    chk({10'h000, flushing}, 11'h000);
    wordReady = 1'b1;
    // pop at the first edge, restart at the second, then five flush edges
    cyc(3);
    chk({10'h000, flushing}, 11'h001);
    cyc(8);
    chk({10'h000, flushing}, 11'h001);
    cyc(2);
    chk({10'h000, flushing}, 11'h000);
    cyc(27);
  endtask : t_stall
  task automatic t_track;
    run = 1'b0;
    cyc(12);
    chk({10'h000, trackOnly}, 11'h001);
    run = 1'b1;
    cyc(4);
    chk({10'h000, trackOnly}, 11'h000);
    cyc(30);
  endtask : t_track
  task automatic t_reset;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(40);
  endtask : t_reset
  task automatic t_drain;
    run = 1'b0;
    for (int i = 0; i < 20 && expq.size() != 0; i++) cyc(1);
    chk(11'(expq.size()), 11'h000);
  endtask : t_drain
  task automatic test_done;
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    cyc(5);
    rst = 1'b0;
    t_stream;
    t_range;
    t_stall;
    t_track;
    t_reset;
    t_drain;
    test_done;
  end
endmodule : testbench
`default_nettype wire
